//--- rtl/rcs_clock_ctrl.sv
// Clock-source control: fuse decode, start-up timing, trim and prescaler.
// Assumes an Avalon-MM master on i_clk and static fuse straps.
// Function
// - Fuse code 0010 selects the internal RC oscillator as system clock.
// - Each reset reloads the factory calibration byte into the trim register.
// - Trim is an eight-bit run-time read/write register, applied immediately.
// - Top trim bit picks lower or upper overlapping frequency range.
// - Low seven trim bits tune frequency monotonically within the range.
// - Watchdog and reset time-out stay on the watchdog oscillator.
// - RC source: 6 CK wake, reset delay 14 CK plus 0/4.1/65 ms.
// - External clock uses the same start-up timing as the RC source.
// - Clock-out fuse drives system clock on the clock-out pin.
// - Clock output continues during reset.
// - Clock-out pin carries the divided system clock.
// - Divide-by-eight fuse divides the clock by 8 at start-up.
// - Prescale register divides the clock for CPU and peripherals.
// - Prescale code n gives division 2**n, up to 8; above reserved.
// - Reset loads prescale 0000, or 0011 with the divide-by-eight fuse.
// - Change enable, then new value within four cycles; enable self-clears.
`timescale 1ns/1ps
`default_nettype none
module rcs_clock_ctrl
  import rcs_pkg::*;
#(
  parameter int unsigned DLY_4MS = DLY_4MS_CYC, // 4.1 ms in cycles
  parameter int unsigned DLY_65MS = DLY_65MS_CYC // 65 ms in cycles
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Async reset, active high
  input wire logic [3:0] i_clock_source_select_fuses, // Source select strap
  input wire logic [1:0] i_startup_time_fuses, // Start-up time strap
  input wire logic i_divide_by_eight_fuse, // Programmed = 1
  input wire logic i_clock_out_fuse, // Programmed = 1
  input wire logic i_wake, // Wake request from power-down
  input wire logic i_gpio_out, // Normal pin function data
  input wire logic i_gpio_oe, // Normal pin function enable
  input wire logic [3:0] i_address, // Avalon byte address
  input wire logic i_read, // Avalon read
  input wire logic i_write, // Avalon write
  input wire logic [31:0] i_writedata, // Avalon write data
  input wire logic [3:0] i_byteenable, // Avalon byte enables
  output logic [31:0] o_readdata, // Avalon read data
  output logic o_waitrequest, // Avalon wait
  output logic [7:0] o_rc_trim, // Trim applied to RC oscillator
  output logic o_rc_select, // RC oscillator is the source
  output logic o_ext_select, // External clock is the source
  output logic o_wdt_osc_for_timeout, // Time-out on watchdog oscillator
  output logic o_core_reset, // Internal reset held
  output logic o_sys_tick, // Divided system clock enable
  output logic o_clock_out_pin, // Pin output value
  output logic o_clock_out_pin_oe // Pin output enable
);
  // ****************************************************************
  // Fuse capture
  // ****************************************************************
  logic [3:0] csel;
  logic [1:0] startup_time_fuses;
  logic div8_fuse;
  logic clock_out_fuse_fuse;
  logic rst_seen;

  // Straps are caught on the first clock after release, then frozen
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_seen <= 1'b0;
      csel <= 4'h0;
      startup_time_fuses <= 2'h0;
      div8_fuse <= 1'b0;
      clock_out_fuse_fuse <= 1'b0;
    end else if (!rst_seen) begin
      rst_seen <= 1'b1;
      csel <= i_clock_source_select_fuses;
      startup_time_fuses <= i_startup_time_fuses;
      div8_fuse <= i_divide_by_eight_fuse;
      clock_out_fuse_fuse <= i_clock_out_fuse;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rc_select <= 1'b0;
      o_ext_select <= 1'b0;
      o_wdt_osc_for_timeout <= 1'b1;
    end else begin
      o_rc_select <= (csel == CSEL_RC);
      o_ext_select <= (csel == CSEL_EXT);
      o_wdt_osc_for_timeout <= 1'b1;
    end
  end

  // ****************************************************************
  // Start-up sequencer
  // ****************************************************************
  rcs_state_t state;
  rcs_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] delay_total;
  logic wake_s1;
  logic wake_s2;
  logic wake_q;

  // Reserved code 11 falls back to the longest delay
  always_comb begin
    case (startup_time_fuses)
      SUT_14CK: delay_total = RESET_CK;
      SUT_4MS: delay_total = RESET_CK + DLY_4MS;
      SUT_65MS: delay_total = RESET_CK + DLY_65MS;
      default: delay_total = RESET_CK + DLY_65MS;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      wake_s1 <= i_wake;
      wake_s2 <= wake_s1;
      wake_q <= wake_s2;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: if (rst_seen) next_state = ST_DELAY;
      ST_DELAY: if (cnt + 32'd1 >= delay_total) next_state = ST_RUN;
      ST_RUN: if (wake_s2 && !wake_q) next_state = ST_WAKE;
      ST_WAKE: if (cnt + 32'd1 >= WAKE_CK) next_state = ST_RUN;
      default: next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_RESET;
      cnt <= 32'h0000_0000;
      o_core_reset <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 32'h0000_0000 : cnt + 32'h0000_0001;
      o_core_reset <= (next_state != ST_RUN);
    end
  end

  // ****************************************************************
  // Register bus and trim
  // ****************************************************************
  logic [3:0] prescale;
  logic pce;
  logic [2:0] pce_cnt;
  logic wr_ack;
  logic bus_req;
  logic wr_trim;
  logic wr_ps;

  assign bus_req = (i_read || i_write) && !wr_ack;
  assign wr_trim = i_write && wr_ack && (i_address == OFS_TRIM) && i_byteenable[0];
  assign wr_ps = i_write && wr_ack && (i_address == OFS_PRESCALE) && i_byteenable[0];

  // One wait cycle per access: request taken, answered the next edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ack <= 1'b0;
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h0000_0000;
    end else begin
      wr_ack <= bus_req;
      o_waitrequest <= !bus_req;
      if (bus_req && i_read) begin
        case (i_address)
          OFS_TRIM: o_readdata <= {24'h000000, o_rc_trim};
          OFS_PRESCALE: o_readdata <= {24'h000000, pce, 3'h0, prescale};
          OFS_STATUS: o_readdata <= {24'h000000, 2'h0, state, 1'b0, o_ext_select,
                                     o_rc_select, o_core_reset};
          OFS_CTRL: o_readdata <= {24'h000000, 2'h0, startup_time_fuses, div8_fuse, clock_out_fuse_fuse,
                                   2'h0};
          default: o_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Trim value reaches the oscillator as soon as written
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rc_trim <= TRIM_FACTORY;
    end else if (wr_trim) begin
      o_rc_trim <= i_writedata[7:0];
    end
  end

  // ****************************************************************
  // Protected prescale register
  // ****************************************************************
  logic ps_loaded;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pce <= 1'b0;
      pce_cnt <= 3'h0;
    end else if (wr_ps && pce && !i_writedata[PCE_BIT]) begin
      pce <= 1'b0;
      pce_cnt <= 3'h0;
    end else if (pce) begin
      // Rewriting the enable neither extends nor clears the window
      if (pce_cnt + 3'h1 >= PCE_WINDOW) begin
        pce <= 1'b0;
        pce_cnt <= 3'h0;
      end else begin
        pce_cnt <= pce_cnt + 3'h1;
      end
    end else if (wr_ps && i_writedata[7:0] == PCE_UNLOCK) begin
      pce <= 1'b1;
      pce_cnt <= 3'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prescale <= PS_DIV1;
      ps_loaded <= 1'b0;
    end else if (!ps_loaded && rst_seen) begin
      ps_loaded <= 1'b1;
      prescale <= div8_fuse ? PS_DIV8 : PS_DIV1;
    end else if (wr_ps && pce && !i_writedata[PCE_BIT]) begin
      prescale <= i_writedata[3:0];
    end
  end

  // ****************************************************************
  // Divider and clock output
  // ****************************************************************
  logic div_tick;
  logic [3:0] eff_sel;
  logic clk_div;

  // Reserved codes run at the largest division
  assign eff_sel = (prescale > PS_MAX) ? PS_MAX : prescale;

  rcs_prescaler u_prescaler (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sel(eff_sel),
    .o_tick(div_tick)
  );

  // Divided clock toggles on each tick, so it keeps running in reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_div <= 1'b0;
      o_sys_tick <= 1'b0;
    end else begin
      o_sys_tick <= div_tick;
      if (div_tick) begin
        clk_div <= !clk_div;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clock_out_pin <= 1'b0;
      o_clock_out_pin_oe <= 1'b0;
    end else if (clock_out_fuse_fuse) begin
      o_clock_out_pin <= clk_div;
      o_clock_out_pin_oe <= 1'b1;
    end else begin
      o_clock_out_pin <= i_gpio_out;
      o_clock_out_pin_oe <= i_gpio_oe;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_RC_SELECT: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(rst_seen) |=> o_rc_select == (csel == CSEL_RC))
    else $error("rc select mismatch");
  AST_TRIM_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_trim |=> o_rc_trim == $past(i_writedata[7:0]))
    else $error("trim write lost");
  AST_TRIM_RESET: assert property (@(posedge i_clk)
    $fell(i_rst) |-> o_rc_trim == TRIM_FACTORY)
    else $error("trim not factory at reset");
  AST_WDT_OSC: assert property (@(posedge i_clk) disable iff (i_rst)
    o_wdt_osc_for_timeout)
    else $error("time-out left watchdog oscillator");
  AST_WAKE_6CK: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_RUN && next_state == ST_WAKE) |=> o_core_reset [*6] ##1 !o_core_reset)
    else $error("wake delay not 6 cycles");
  AST_RESET_14CK: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_RESET && next_state == ST_DELAY && startup_time_fuses == SUT_14CK)
      |=> o_core_reset [*7] ##1 o_core_reset [*7] ##1 !o_core_reset)
    else $error("reset delay not 14 cycles");
  AST_CLKOUT: assert property (@(posedge i_clk) disable iff (i_rst)
    clock_out_fuse_fuse |=> o_clock_out_pin_oe && o_clock_out_pin == $past(clk_div))
    else $error("clock out not driven");
  AST_DIV8: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(ps_loaded) |-> prescale == (div8_fuse ? PS_DIV8 : PS_DIV1))
    else $error("prescale reset value wrong");
  AST_PCE_WINDOW: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(pce) |-> ##[1:4] !pce)
    else $error("change enable outlived window");
  AST_PS_GUARD: assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(ps_loaded) && !$past(pce) && $changed(prescale)) |-> 1'b0)
    else $error("prescale changed without enable");
  AST_EXT_SELECT: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(rst_seen) |=> o_ext_select == (csel == CSEL_EXT))
    else $error("external select mismatch");
  AST_FUSE_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
    rst_seen |=> $stable(csel) && $stable(startup_time_fuses) && $stable(div8_fuse) && $stable(clock_out_fuse_fuse))
    else $error("fuse capture moved");
  AST_TRIM_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
    !wr_trim |=> $stable(o_rc_trim))
    else $error("trim changed without write");
  AST_BUS_WAIT: assert property (@(posedge i_clk) disable iff (i_rst)
    bus_req |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus answer not one wait state");
  AST_PCE_SET: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ps && !pce && i_writedata[7:0] == PCE_UNLOCK) |=> pce)
    else $error("change enable not set");
  AST_PS_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
    (ps_loaded && wr_ps && pce && !i_writedata[PCE_BIT])
      |=> prescale == $past(i_writedata[3:0]) && !pce)
    else $error("enabled prescale write lost");
  AST_PS_LOCKED: assert property (@(posedge i_clk) disable iff (i_rst)
    (ps_loaded && wr_ps && !pce) |=> $stable(prescale))
    else $error("prescale written while locked");
  AST_CLKOUT_GPIO: assert property (@(posedge i_clk) disable iff (i_rst)
    !clock_out_fuse_fuse |=> o_clock_out_pin == $past(i_gpio_out)
      && o_clock_out_pin_oe == $past(i_gpio_oe))
    else $error("pin lost its normal function");
  CV_WAKE: cover property (@(posedge i_clk) disable iff (i_rst) state == ST_WAKE);
  CV_PS_CHANGE: cover property (@(posedge i_clk) disable iff (i_rst)
    wr_ps && pce && !i_writedata[PCE_BIT]);
  CV_TRIM: cover property (@(posedge i_clk) disable iff (i_rst) wr_trim);
  CV_CLKOUT_IN_RESET: cover property (@(posedge i_clk) disable iff (i_rst)
    o_core_reset && o_clock_out_pin_oe && $changed(o_clock_out_pin));
  CV_PCE_EXPIRE: cover property (@(posedge i_clk) disable iff (i_rst)
    $fell(pce) && !$past(wr_ps));
endmodule : rcs_clock_ctrl
`default_nettype wire

//--- rtl/rcs_pkg.sv
// Package: constants for the clock-source select and prescaler block.
// Assumes one 100 MHz clock; fuse inputs are static straps.
package rcs_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // Register offsets (byte addresses on a 32-bit Avalon-MM bus)
  localparam logic [3:0] OFS_TRIM = 4'h0;
  localparam logic [3:0] OFS_PRESCALE = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hC;
  // Prescale register fields
  localparam int unsigned PCE_BIT = 7;
  localparam logic [3:0] PS_DIV1 = 4'h0;
  localparam logic [3:0] PS_DIV8 = 4'h3;
  localparam logic [3:0] PS_MAX = 4'h8;
  localparam logic [7:0] PCE_UNLOCK = 8'h80;
  localparam logic [2:0] PCE_WINDOW = 3'h4;
  // Fuse codes
  localparam logic [3:0] CSEL_RC = 4'h2;
  localparam logic [3:0] CSEL_EXT = 4'h0;
  localparam logic [1:0] SUT_14CK = 2'h0;
  localparam logic [1:0] SUT_4MS = 2'h1;
  localparam logic [1:0] SUT_65MS = 2'h2;
  // Start-up timing
  localparam int unsigned WAKE_CK = 6;
  localparam int unsigned RESET_CK = 14;
  localparam int unsigned DLY_4MS_US = 4100;
  localparam int unsigned DLY_65MS_US = 65000;
  localparam int unsigned DLY_4MS_CYC = DLY_4MS_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DLY_65MS_CYC = DLY_65MS_US * (CLK_HZ / 1_000_000);
  // Factory calibration byte (arbitrary neutral value)
  localparam logic [7:0] TRIM_FACTORY = 8'h5A;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b10,
    ST_WAKE = 2'b11
  } rcs_state_t;
endpackage : rcs_pkg

//--- rtl/rcs_prescaler.sv
// Prescaler: divides the source clock enable by 2**sel, sel up to 8.
// Assumes sel is held steady between updates; counter restarts on change.
`timescale 1ns/1ps
`default_nettype none
module rcs_prescaler
  import rcs_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Async reset, active high
  input wire logic [3:0] i_sel, // Division code
  output logic o_tick // One-cycle enable at divided rate
);
  logic [8:0] cnt;
  logic [3:0] sel_q;
  logic [8:0] limit;

  assign limit = (9'h001 << i_sel) - 9'h001;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 9'h000;
      sel_q <= 4'h0;
      o_tick <= 1'b0;
    end else begin
      sel_q <= i_sel;
      // Restart on a setting change so no shortened period appears
      if (sel_q != i_sel || cnt >= limit) begin
        cnt <= 9'h000;
        o_tick <= (sel_q == i_sel);
      end else begin
        cnt <= cnt + 9'h001;
        o_tick <= 1'b0;
      end
    end
  end
endmodule : rcs_prescaler
`default_nettype wire

//--- bench/rcs_clk_load.sv
// Partner model: a circuit clocked from the clock-out pin.
// Assumes the pin is sampled on the system clock; reports its half period.
`timescale 1ns/1ps
`default_nettype none
module rcs_clk_load (
  input wire logic i_clk, // Sampling clock
  input wire logic i_rst, // Clears the measurement
  input wire logic i_pin, // Clock-out pin level
  input wire logic i_pin_oe, // Pin is driven
  output logic [15:0] o_half_period // Cycles between the last two pin edges
);
  logic pin_q;
  logic [15:0] run_count;
  // ****************************************
  // Edge spacing of the driven clock
  // ****************************************
  // Only takes edges while the pin is driven, so an undriven gpio level never looks like a clock
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_q <= 1'b0;
      run_count <= 16'h0000;
      o_half_period <= 16'h0000;
    end else begin
      pin_q <= i_pin;
      if (i_pin_oe && (i_pin != pin_q)) begin
        o_half_period <= run_count + 16'h0001;
        run_count <= 16'h0000;
      end else begin
        run_count <= run_count + 16'h0001;
      end
    end
  end
endmodule : rcs_clk_load
`default_nettype wire

//--- bench/rcs_clock_ctrl_tb.sv
// Testbench for the clock-source control block: bus tasks and directed tests.
// Assumes the package, the design and the pin load model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rcs_clock_ctrl_tb;
  import rcs_pkg::*;
  localparam int unsigned D4 = 20;
  localparam int unsigned D65 = 40;
  logic i_clk, i_rst, i_divide_by_eight_fuse, i_clock_out_fuse, i_wake;
  logic i_gpio_out, i_gpio_oe, i_read, i_write;
  logic [3:0] i_clock_source_select_fuses, i_address, i_byteenable;
  logic [1:0] i_startup_time_fuses;
  logic [31:0] i_writedata, o_readdata, rd;
  logic o_waitrequest, o_rc_select, o_ext_select, o_wdt_osc_for_timeout, o_core_reset;
  logic o_sys_tick, o_clock_out_pin, o_clock_out_pin_oe;
  logic [7:0] o_rc_trim;
  logic [15:0] half_period;
  int err_total, compares, run_cycles, gap, n;
  int st[4];
  rcs_clock_ctrl #(.DLY_4MS(D4), .DLY_65MS(D65)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_clock_source_select_fuses(i_clock_source_select_fuses),
    .i_startup_time_fuses(i_startup_time_fuses), .i_divide_by_eight_fuse(i_divide_by_eight_fuse),
    .i_clock_out_fuse(i_clock_out_fuse), .i_wake(i_wake), .i_gpio_out(i_gpio_out),
    .i_gpio_oe(i_gpio_oe), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_rc_trim(o_rc_trim), .o_rc_select(o_rc_select),
    .o_ext_select(o_ext_select), .o_wdt_osc_for_timeout(o_wdt_osc_for_timeout),
    .o_core_reset(o_core_reset), .o_sys_tick(o_sys_tick), .o_clock_out_pin(o_clock_out_pin),
    .o_clock_out_pin_oe(o_clock_out_pin_oe));
  rcs_clk_load u_load (.i_clk(i_clk), .i_rst(i_rst), .i_pin(o_clock_out_pin),
    .i_pin_oe(o_clock_out_pin_oe), .o_half_period(half_period));
  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic final_report();
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  always @(posedge i_clk) begin
    run_cycles++;
    if (run_cycles == 20000) begin
      err_total++;
      final_report();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Leading edge keeps a release and the next request out of one time step
  task automatic bus_xfer(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge i_clk);
    i_address <= adr;
    i_writedata <= wd;
    i_read <= !wr;
    i_write <= wr;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask : bus_xfer
  task automatic restart(input logic [3:0] cs, input logic [1:0] startup_time_fuses, input logic d8,
                         input logic ck, output int cyc);
    @(posedge i_clk);
    i_rst <= 1'b1;
    i_clock_source_select_fuses <= cs;
    i_startup_time_fuses <= startup_time_fuses;
    i_divide_by_eight_fuse <= d8;
    i_clock_out_fuse <= ck;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    cyc = 0;
    do begin
      @(posedge i_clk);
      cyc++;
      if (cyc == 6) check("pin oe in reset", o_clock_out_pin_oe, ck);
    end while (o_core_reset !== 1'b0 && cyc < 300);
  endtask : restart
  task automatic tick_gap();
    do @(posedge i_clk); while (o_sys_tick !== 1'b1);
    gap = 0;
    do begin
      @(posedge i_clk);
      gap++;
    end while (o_sys_tick !== 1'b1 && gap < 600);
  endtask : tick_gap
  // ****************************************
  // Directed sequence
  // ****************************************
  initial begin
    {i_read, i_write, i_wake, i_gpio_out, i_gpio_oe} = 5'h00;
    {i_address, i_writedata, i_byteenable} = {4'h0, 32'h0, 4'hF};
    {i_clock_source_select_fuses, i_startup_time_fuses} = {CSEL_RC, SUT_14CK};
    {i_divide_by_eight_fuse, i_clock_out_fuse} = 2'h3;
    {err_total, compares, run_cycles} = {32'h0, 32'h0, 32'h0};
    i_rst = 1'b1;
    for (n = 0; n < 4; n++) restart(CSEL_RC, n[1:0], 1'b1, 1'b1, st[n]);
    check("delay 14CK", st[0] >= 14 && st[0] <= 18, 1'b1);
    check("delay 4.1ms", st[1] - st[0], D4);
    check("delay 65ms", st[2] - st[0], D65);
    check("delay reserved", st[3] - st[0], D65);
    check("source flags", {o_rc_select, o_ext_select, o_wdt_osc_for_timeout}, 3'b101);
    bus_xfer(1'b0, OFS_STATUS, 32'h0);
    check("status", rd[2:0], 3'b010);
    bus_xfer(1'b0, OFS_TRIM, 32'h0);
    check("trim reset", rd[7:0], TRIM_FACTORY);
    bus_xfer(1'b0, OFS_PRESCALE, 32'h0);
    check("prescale reset", rd[3:0], PS_DIV8);
    tick_gap();
    tick_gap();
    check("div8 gap", gap, 8);
    {i_startup_time_fuses, i_divide_by_eight_fuse, i_clock_source_select_fuses} <= 7'h00;
    bus_xfer(1'b0, OFS_CTRL, 32'h0);
    check("fuses held", {rd[5:2], o_rc_select}, 5'h1F);
    // No memory writes in this run, so the whole trim span is allowed
    for (n = 0; n < 4; n++) begin
      bus_xfer(1'b1, OFS_TRIM, {24'h0, 8'(8'h7F + n * 8'h40)});
      @(posedge i_clk);
      check("trim applied", o_rc_trim, 8'(8'h7F + n * 8'h40));
      bus_xfer(1'b0, OFS_TRIM, 32'h0);
      check("trim read", rd[7:0], 8'(8'h7F + n * 8'h40));
    end
    bus_xfer(1'b0, 4'h1, 32'h0);
    check("unmapped read", rd, 32'h0);
    for (n = 0; n < 10; n++) begin
      bus_xfer(1'b1, OFS_PRESCALE, {24'h0, PCE_UNLOCK});
      bus_xfer(1'b1, OFS_PRESCALE, {28'h0, n[3:0]});
      bus_xfer(1'b0, OFS_PRESCALE, 32'h0);
      check("prescale read", rd[7:0], {4'h0, n[3:0]});
      tick_gap();
      tick_gap();
      check("prescale gap", gap, (n > 8) ? 256 : (1 << n));
      repeat (3) @(posedge i_clk);
      check("pin half period", half_period, (n > 8) ? 256 : (1 << n));
    end
    bus_xfer(1'b1, OFS_PRESCALE, 32'h2);
    bus_xfer(1'b1, OFS_PRESCALE, {24'h0, PCE_UNLOCK});
    repeat (6) @(posedge i_clk);
    bus_xfer(1'b1, OFS_PRESCALE, 32'h1);
    bus_xfer(1'b0, OFS_PRESCALE, 32'h0);
    check("locked prescale", rd[3:0], 4'h9);
    i_wake <= 1'b1;
    n = 0;
    while (o_core_reset !== 1'b1 && n < 10) begin
      @(posedge i_clk);
      n++;
    end
    for (n = 0; o_core_reset === 1'b1 && n < 20; n++) @(posedge i_clk);
    check("wake cycles", n, WAKE_CK);
    i_wake <= 1'b0;
    restart(CSEL_EXT, SUT_14CK, 1'b0, 1'b0, n);
    check("ext delay", n, st[0]);
    check("ext flags", {o_rc_select, o_ext_select}, 2'b01);
    bus_xfer(1'b0, OFS_PRESCALE, 32'h0);
    check("prescale reset", rd[3:0], PS_DIV1);
    bus_xfer(1'b0, OFS_TRIM, 32'h0);
    check("trim reload", rd[7:0], TRIM_FACTORY);
    {i_gpio_out, i_gpio_oe} <= 2'b11;
    repeat (2) @(posedge i_clk);
    check("gpio pin", {o_clock_out_pin, o_clock_out_pin_oe}, 2'b11);
    final_report();
  end
endmodule : rcs_clock_ctrl_tb
`default_nettype wire
